// *** verilog/led_sink_ctrl.sv ***
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// R1: blanking high forces all sixteen sinks off and turns every pre-charge pull-up on.
// R2: blanking low drives each sink from its latch bit and keeps all pull-ups off.
// R3: with blanking low a sink is on for latch bit one and off for zero.
// R4: an undriven blanking input reads high, so outputs default off.
// R5: while the transfer gate is high the latch follows the shift register, shifts included.
// R6: while the transfer gate is low the latch holds regardless of shifting.
// R7: an undriven transfer gate reads low, so the latch holds by default.
// R8: each rising shift clock moves every shift bit one place toward the msb.
// R9: each rising shift clock loads the lsb with the serial input level.
// R10: the chain output shows the shift register msb and changes only on rising shift clock.
// R11: shift register and latch have no power-up value; the controller loads them under blanking.
// R12: bit n of shift register and latch controls sink channel n, lsb for channel zero.
// R13: the controller shifts sixteen bits per device msb first with the gate low, then pulses the gate.
module led_sink_ctrl
    import led_sink_pkg::*;
(
    input  wire logic                          core_clk,                  // register and output clock
    input  wire logic                          reset_n,                   // asynchronous, active low
    // link pins
    input  wire logic                          shift_clk,                 // serial shift clock
    input  wire logic                          serial_data_in,            // serial data
    input  wire logic                          transfer_gate,             // latch transfer level
    input  wire logic                          transfer_gate_driven,      // gate pin is driven
    input  wire logic                          blank_in,                  // blanking level
    input  wire logic                          blank_driven,              // blank pin is driven
    output logic                               serial_chain_out,          // daisy chain data
    output logic          [CHANNELS-1:0]       sink_channel,              // sink on per channel
    output logic          [CHANNELS-1:0]       precharge_on,              // pull-up on per channel
    // axi4-lite slave
    input  wire logic     [ADDR_W-1:0]         s_axi_awaddr,              // write address
    input  wire logic                          s_axi_awvalid,             // write address valid
    output logic                               s_axi_awready,             // write address ready
    input  wire logic     [31:0]               s_axi_wdata,               // write data
    input  wire logic     [3:0]                s_axi_wstrb,               // byte strobes
    input  wire logic                          s_axi_wvalid,              // write data valid
    output logic                               s_axi_wready,              // write data ready
    output logic          [1:0]                s_axi_bresp,               // write response
    output logic                               s_axi_bvalid,              // write response valid
    input  wire logic                          s_axi_bready,              // write response ready
    input  wire logic     [ADDR_W-1:0]         s_axi_araddr,              // read address
    input  wire logic                          s_axi_arvalid,             // read address valid
    output logic                               s_axi_arready,             // read address ready
    output logic          [31:0]               s_axi_rdata,               // read data
    output logic          [1:0]                s_axi_rresp,               // read response
    output logic                               s_axi_rvalid,              // read data valid
    input  wire logic                          s_axi_rready               // read data ready
);
    import led_sink_pkg::*;

    // ****************************************************************
    // link domain
    // ****************************************************************
    // the shift register and chain output run on shift_clk alone, the latch on the gate level;
    // the core side only sees them through the crossing below
    logic                 gate_level;
    logic [CHANNELS-1:0]  link_shift;
    logic [CHANNELS-1:0]  link_latch;

    // floating gate reads low through the pull-down
    assign gate_level = transfer_gate_driven & transfer_gate; // see R7

    // chain output leaves straight from the link flop, no core delay
    led_sink_link u_link (
        .shift_clk        (shift_clk),
        .serial_data_in   (serial_data_in),
        .transfer_gate    (gate_level),
        .serial_chain_out (serial_chain_out),
        .shift_bits       (link_shift),
        .latch_bits       (link_latch)
    );

    // ****************************************************************
    // crossing into core_clk
    // ****************************************************************
    // every bit passes two flops; a word caught mid-shift may still be torn
    // in snap_sync, so only the settle filter below reads it
    // the link logic has no reset, so these show unknown until it is loaded
    link_snapshot_t  snap_meta;
    link_snapshot_t  snap_sync;
    link_snapshot_t  snap_prev;
    logic [1:0]      blank_meta;
    logic [1:0]      blank_sync;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            snap_meta <= '0;
            snap_sync <= '0;
            snap_prev <= '0;
        end else begin
            snap_meta <= '{shift_bits: link_shift, latch_bits: link_latch};
            snap_sync <= snap_meta;
            snap_prev <= snap_sync;
        end
    end

    // blank and gate pin levels through two flops; floating blank reads high
    // bit one carries the gate level, for the status word only
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            blank_meta <= 2'h1;
            blank_sync <= 2'h1;
        end else begin
            blank_meta <= {gate_level, ~blank_driven | blank_in}; // see R4
            blank_sync <= blank_meta;
        end
    end

    // ****************************************************************
    // settle filter
    // ****************************************************************
    // a word is taken only when two successive synchronised samples
    // agree, so a shift landing on a sampling edge cannot tear it;
    // the price is two more core_clk cycles on the latch path
    link_snapshot_t  snap_stable;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            snap_stable <= '0;
        end else if (snap_sync == snap_prev) begin
            snap_stable <= snap_sync;
        end
    end

    // ****************************************************************
    // control register
    // ****************************************************************
    // control holds the software blank force and a software-only flag;
    // reset leaves blank forced so no sink lights on random latch data;
    // only byte lane zero can change the control bits
    logic [1:0]  control;
    logic        blank_eff;
    logic        aw_held;
    logic        w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_fire;

    // a write fires once both halves are held and no response waits
    assign wr_fire = aw_held & w_held & ~s_axi_bvalid;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            control <= CTRL_RESET;
        end else if (wr_fire && aw_addr == REG_CONTROL && w_strb[0]) begin
            control <= w_data[1:0];
        end
    end

    // software blank adds to the pin and never masks it, so a high
    // blank pin always wins whatever the control word holds
    assign blank_eff = control[CTRL_BLANK_BIT] | blank_sync[STAT_BLANK_BIT]; // see R1 see R4

    // ****************************************************************
    // output drive
    // ****************************************************************
    // pin to sink takes three core_clk edges, latch to sink five
    drive_t next_drive;

    // blanking wins over the latch in every case
    always_comb begin
        if (blank_eff) begin
            next_drive.sink_on      = '0;   // see R1
            next_drive.precharge_on = 1'b1; // see R1
        end else begin
            next_drive.sink_on      = snap_stable.latch_bits; // see R2 see R3 see R12
            next_drive.precharge_on = 1'b0;                 // see R2
        end
    end

    // sinks from their own flop; reset keeps every sink off
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sink_channel <= '0;
        end else begin
            sink_channel <= next_drive.sink_on;
        end
    end

    // pull-ups from their own flop; reset leaves them all on, as blanked
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            precharge_on <= '1;
        end else begin
            precharge_on <= {CHANNELS{next_drive.precharge_on}};
        end
    end

    // ****************************************************************
    // axi4-lite write channel
    // ****************************************************************
    // address and data may arrive in either order; each half is held
    // until the write fires
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    // data half, with the strobes that gate the control byte
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // address ready only while no address is held and no response waits
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
        end
    end

    // data ready follows the same rule for the data half
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_wready  <= ~w_held & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
        end
    end

    // only the control word is writable; anything else answers slverr
    // the response stands until bready, and no new write is taken before
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == REG_CONTROL) ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // axi4-lite read channel
    // ****************************************************************
    // unmapped words read as zero; status comes from the pin synchronisers
    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] addr);
        case (addr)
            REG_CONTROL: read_word = {30'h0, control};
            REG_LATCH:   read_word = {16'h0, snap_stable.latch_bits};
            REG_SHIFT:   read_word = {16'h0, snap_stable.shift_bits};
            REG_OUTPUTS: read_word = {15'h0, precharge_on[0], sink_channel};
            REG_STATUS:  read_word = {30'h0, blank_sync};
            default:     read_word = 32'h0;
        endcase
    endfunction

    // decode behind the read response code
    function automatic logic addr_known(input logic [ADDR_W-1:0] addr);
        case (addr)
            REG_CONTROL,
            REG_LATCH,
            REG_SHIFT,
            REG_OUTPUTS,
            REG_STATUS: addr_known = 1'b1;
            default:    addr_known = 1'b0;
        endcase
    endfunction

    // one read at a time: ready stays low while a response waits
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
        end
    end

    // data and response are latched together at the address handshake
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= read_word(s_axi_araddr);
            s_axi_rresp  <= addr_known(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// *** verilog/led_sink_pkg.sv ***
package led_sink_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int CHANNELS = 16;
    localparam int ADDR_W   = 8;

    // ****************************************************************
    // register map (byte addresses, one aligned word each)
    // ****************************************************************
    localparam logic [ADDR_W-1:0] REG_CONTROL  = 8'h00; // [0] blank_force, [1] pins_override
    localparam logic [ADDR_W-1:0] REG_LATCH    = 8'h04; // output control latch, read only
    localparam logic [ADDR_W-1:0] REG_SHIFT    = 8'h08; // shift register, read only
    localparam logic [ADDR_W-1:0] REG_OUTPUTS  = 8'h0c; // sink state [15:0], precharge [16]
    localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h10; // [0] blank level, [1] gate level

    // field positions
    localparam int CTRL_BLANK_BIT = 0;
    localparam int CTRL_OVR_BIT   = 1;
    localparam int OUT_PCHG_BIT   = 16;
    localparam int STAT_BLANK_BIT = 0;
    localparam int STAT_GATE_BIT  = 1;

    // reset values
    localparam logic [1:0]  CTRL_RESET = 2'h1; // blank forced from reset until software writes
    localparam logic [1:0]  AXI_OKAY   = 2'h0;
    localparam logic [1:0]  AXI_SLVERR = 2'h2;

    // state of the link side bundled for the crossing
    typedef struct packed {
        logic [CHANNELS-1:0] shift_bits;
        logic [CHANNELS-1:0] latch_bits;
    } link_snapshot_t;

    typedef struct packed {
        logic [CHANNELS-1:0] sink_on;
        logic                precharge_on;
    } drive_t;

endpackage

// *** verilog/led_sink_link.sv ***
`timescale 1ns/1ps
// link side: shift register and level-sensitive transfer latch
module led_sink_link
    import led_sink_pkg::*;
(
    input  wire logic                      shift_clk,        // serial shift clock from controller
    input  wire logic                      serial_data_in,   // serial bit, sampled at rising shift_clk
    input  wire logic                      transfer_gate,    // latch follows shift register while high
    output logic                           serial_chain_out, // msb of shift register
    output logic          [CHANNELS-1:0]   shift_bits,       // shift register contents
    output logic          [CHANNELS-1:0]   latch_bits        // output control latch
);

    // ****************************************************************
    // shift register
    // ****************************************************************
    // no reset: contents undefined at power-up, the controller must load it
    always_ff @(posedge shift_clk) begin
        shift_bits <= {shift_bits[CHANNELS-2:0], serial_data_in}; // see R8 see R9 see R11
    end

    // chain output only moves on a rising shift edge
    always_ff @(posedge shift_clk) begin
        serial_chain_out <= shift_bits[CHANNELS-2]; // see R10
    end

    // ****************************************************************
    // transfer latch
    // ****************************************************************
    // a true level latch: transparent while the gate is high, also across shifts
    always_latch begin
        if (transfer_gate) begin
            latch_bits = shift_bits; // see R5
        end
    end
    // while the gate is low nothing is assigned, so the latch holds (see R6)

endmodule

// *** testbench/led_sink_ctrl_sva.sv ***
`timescale 1ns/1ps
module led_sink_ctrl_sva
    import led_sink_pkg::*;
(
    input wire logic                core_clk,      // core clock
    input wire logic                reset_n,       // async reset, active low
    input wire logic                blank_in,      // blanking pin level
    input wire logic                blank_driven,  // blanking pin driven
    input wire logic [CHANNELS-1:0] sink_channel,  // sink on per channel
    input wire logic [CHANNELS-1:0] precharge_on,  // pull-up per channel
    input wire logic [ADDR_W-1:0]   s_axi_awaddr,  // write address
    input wire logic                s_axi_awvalid, // write address valid
    input wire logic                s_axi_awready, // write address ready
    input wire logic                s_axi_wvalid,  // write data valid
    input wire logic                s_axi_wready,  // write data ready
    input wire logic [1:0]          s_axi_bresp,   // write response
    input wire logic                s_axi_bvalid,  // write response valid
    input wire logic                s_axi_bready,  // write response ready
    input wire logic [ADDR_W-1:0]   s_axi_araddr,  // read address
    input wire logic                s_axi_arvalid, // read address valid
    input wire logic                s_axi_arready, // read address ready
    input wire logic [31:0]         s_axi_rdata,   // read data
    input wire logic [1:0]          s_axi_rresp,   // read response
    input wire logic                s_axi_rvalid,  // read valid
    input wire logic                s_axi_rready   // read ready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // ****************************************************************
    // outputs and blanking
    // ****************************************************************
    // pull-ups switch as one group, never a partial set
    a_pchg_uniform: assert property (precharge_on == 16'h0000 || precharge_on == 16'hffff)
        else $error("precharge outputs disagree");
    a_blank_sinks_off: assert property (precharge_on[0] |-> sink_channel == 16'h0000)
        else $error("sink on while blanked");
    // two sync flops plus the output flop, so five pin cycles is ample
    a_pin_blank_off: assert property ((blank_driven && blank_in)[*5] |-> (&precharge_on && sink_channel == 16'h0000))
        else $error("blank pin did not blank");
    a_float_blank_off: assert property ((!blank_driven)[*5] |-> (&precharge_on && sink_channel == 16'h0000))
        else $error("floating blank did not blank");

    // ****************************************************************
    // register bus
    // ****************************************************************
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_ro_write_err: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr != REG_CONTROL |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == AXI_SLVERR))
        else $error("write outside control not refused");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > REG_STATUS
        |=> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
endmodule

bind led_sink_ctrl led_sink_ctrl_sva u_sva (.core_clk, .reset_n, .blank_in, .blank_driven, .sink_channel,
    .precharge_on, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

// *** testbench/led_sink_host_model.sv ***
`timescale 1ns/1ps
module led_sink_host_model (
    output logic shift_clk,      // stands low between frames
    output logic serial_data_in, // serial bit
    output logic transfer_gate   // transfer level
);
    initial begin
        shift_clk = 1'b0;
        serial_data_in = 1'b0;
        transfer_gate = 1'b0;
    end

    // msb first, data set on the low half so it is steady at the rise
    task automatic send_word(input logic [15:0] w, input logic gate);
        #7 transfer_gate = gate;
        for (int i = 15; i >= 0; i--) begin
            serial_data_in = w[i];
            #24 shift_clk = 1'b1;
            #24 shift_clk = 1'b0;
        end
        serial_data_in = ~w[0]; // released line shows a changed level
        transfer_gate = 1'b0;
        #96; // let the word settle across the crossing before anyone reads it
    endtask

    // one link period high after the word is complete
    task automatic pulse_gate();
        #24 transfer_gate = 1'b1;
        #48 transfer_gate = 1'b0;
        #96; // settle time for the latch word on the core side
    endtask
endmodule

// *** testbench/led_sink_ctrl_tb.sv ***
`timescale 1ns/1ps
module led_sink_ctrl_tb;
    import led_sink_pkg::*;
    logic core_clk = 1'b0, reset_n = 1'b0, transfer_gate_driven = 1'b1, blank_in = 1'b0, blank_driven = 1'b1;
    logic shift_clk, serial_data_in, transfer_gate, serial_chain_out;
    logic [CHANNELS-1:0] sink_channel, precharge_on;
    logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int errors = 0, num_checks = 0, cycles = 0;

    led_sink_host_model ctl (.shift_clk, .serial_data_in, .transfer_gate);
    led_sink_ctrl DUT (.core_clk, .reset_n, .shift_clk, .serial_data_in, .transfer_gate, .transfer_gate_driven,
        .blank_in, .blank_driven, .serial_chain_out, .sink_channel, .precharge_on, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    // ****************************************************************
    // clock, timeout and reporting
    // ****************************************************************
    always #12.5 core_clk = ~core_clk;

    // the whole run needs a few hundred cycles, so this only trips on a hang
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: resp %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [15:0] s, input logic [15:0] p);
        repeat (5) @(posedge core_clk);
        chk_data({16'h0, sink_channel}, {16'h0, s});
        chk_data({16'h0, precharge_on}, {16'h0, p});
    endtask

    // ****************************************************************
    // register bus master
    // ****************************************************************
    // both channels offered at once, each dropped at its own handshake
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin do @(posedge core_clk); while (s_axi_awready !== 1'b1); s_axi_awvalid <= 1'b0; end
            begin do @(posedge core_clk); while (s_axi_wready !== 1'b1); s_axi_wvalid <= 1'b0; end
        join
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        chk_resp(rsp, exp);
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk_data(s_axi_rdata, exp);
        chk_resp(s_axi_rresp, exp_r);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        chk_out(16'h0000, 16'hffff);
        axi_read(REG_CONTROL, {30'h0, CTRL_RESET}, AXI_OKAY);
        $display("reset test done");
        ctl.send_word(16'ha5c3, 1'b0);
        axi_read(REG_SHIFT, 32'h0000a5c3, AXI_OKAY);
        chk_data({31'h0, serial_chain_out}, 32'h1);
        ctl.pulse_gate();
        axi_read(REG_LATCH, 32'h0000a5c3, AXI_OKAY);
        chk_out(16'h0000, 16'hffff);
        axi_write(REG_CONTROL, 32'h0, AXI_OKAY);
        chk_out(16'ha5c3, 16'h0000);
        axi_read(REG_OUTPUTS, 32'h0000a5c3, AXI_OKAY);
        $display("load test done");
        ctl.send_word(16'h0ff0, 1'b0);
        chk_out(16'ha5c3, 16'h0000);
        axi_read(REG_SHIFT, 32'h00000ff0, AXI_OKAY);
        chk_data({31'h0, serial_chain_out}, 32'h0);
        transfer_gate_driven <= 1'b0;
        ctl.send_word(16'h1234, 1'b1);
        chk_out(16'ha5c3, 16'h0000);
        transfer_gate_driven <= 1'b1;
        ctl.send_word(16'h1234, 1'b1);
        chk_out(16'h1234, 16'h0000);
        $display("gate test done");
        blank_in <= 1'b1;
        chk_out(16'h0000, 16'hffff);
        blank_driven <= 1'b0;
        blank_in <= 1'b0;
        chk_out(16'h0000, 16'hffff);
        blank_driven <= 1'b1;
        chk_out(16'h1234, 16'h0000);
        blank_in <= 1'b1;
        axi_write(REG_CONTROL, 32'h2, AXI_OKAY);
        chk_out(16'h0000, 16'hffff);
        axi_read(REG_STATUS, 32'h00000001, AXI_OKAY);
        blank_in <= 1'b0;
        chk_out(16'h1234, 16'h0000);
        $display("blank test done");
        axi_write(REG_LATCH, 32'h0000ffff, AXI_SLVERR);
        axi_read(8'h14, 32'h0, AXI_SLVERR);
        axi_read(REG_LATCH, 32'h00001234, AXI_OKAY);
        $display("register test done");
        stop_test();
    end
endmodule
